// ==== design/csma_cd_mac_duplex_filter.sv ====
// Media access unit: register port, MII transmit and receive with frame filtering
// Summary of operation
// RULE1 - Runs at 10 or 100 Mbps, sending, receiving and handling collisions by CSMA/CD.
// RULE2 - Nibble data with PHY over MII; clocks 25 MHz or 2.5 MHz.
// RULE3 - Full duplex sends and receives together; sending ignores receive path.
// RULE4 - Reception starts only when PHY reports a valid frame.
// RULE5 - MAC duplex comes from configuration or tracks PHY-reported duplex only.
// RULE6 - PHY duplex from auto-negotiation, else PHY management register 0 bit 8.
// RULE7 - PHY advertises full duplex by default regardless of MAC duplex.
// RULE8 - Software should set MAC duplex equal to the negotiated result.
// RULE9 - Flow control uses only pause frames, not meant for shared media.
// RULE10 - Flow control mode chosen by configuration: transmit, receive or none.
// RULE11 - PHY duplex and flow enable set by auto-negotiation or management writes.
// RULE12 - Optionally ignore universal/local bit in individual address match.
// RULE13 - Ignore option touches only individual match, no priority given.
// RULE14 - Frames over 1518 bytes accepted only with long-frame bit set.
// RULE15 - Loaded station address used until an address setup command replaces it. Here writes to REG_ADDR_LO and REG_ADDR_HI also replace it.
// RULE16 - Frames of 1518 bytes or fewer pass the length check always.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mac_regs.svh"
module csma_cd_mac_duplex_filter #(
	parameter logic [47:0] LOADED_ADDRESS = 48'h00_00_00_00_00_02,
	parameter int MAX_COLL = 16
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic station_address_setup_cmd,
	input wire logic [47:0] setup_address,
	output logic phy_adv_full_duplex,
	input wire logic phy_an_enable,
	input wire logic phy_an_full_duplex,
	input wire logic [15:0] phy_mgmt_register,
	output logic [15:0] phy_mgmt_wdata,
	output logic phy_mgmt_wr,
	input wire logic mii_tx_clk,
	output logic [3:0] mii_txd,
	output logic mii_tx_en,
	input wire logic mii_crs,
	input wire logic mii_col,
	input wire logic mii_rx_clk,
	input wire logic [3:0] mii_rxd,
	input wire logic mii_rx_dv,
	output logic rx_frame_accepted,
	output logic rx_frame_dropped
);
	if (MAX_COLL < 1 || MAX_COLL > 255) begin : g_coll_check
		$error("MAX_COLL out of range");
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [31:0] ctrl_r;
	logic [47:0] station_address_r;
	logic [7:0] tx_byte_r;
	logic tx_go_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_r <= `CTRL_RESET;
			tx_byte_r <= 8'h00;
			tx_go_r <= 1'b0;
		end else begin
			tx_go_r <= 1'b0;
			if (reg_wr && reg_addr == `REG_CTRL) begin
				ctrl_r <= reg_wdata;
				tx_go_r <= reg_wdata[`CTRL_TX_GO];
			end
			if (reg_wr && reg_addr == `REG_TX_DATA)
				tx_byte_r <= reg_wdata[7:0];
		end
	end

	// Station address: loaded value until a setup command or register write
	logic addr_loaded_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			addr_loaded_r <= 1'b0;
			station_address_r <= 48'h0;
		end else if (!addr_loaded_r) begin
			addr_loaded_r <= 1'b1;
			station_address_r <= LOADED_ADDRESS; // [RULE15]
		end else if (station_address_setup_cmd) begin
			station_address_r <= setup_address; // [RULE15]
		end else if (reg_wr && reg_addr == `REG_ADDR_LO) begin
			station_address_r[31:0] <= reg_wdata;
		end else if (reg_wr && reg_addr == `REG_ADDR_HI) begin
			station_address_r[47:32] <= reg_wdata[15:0];
		end
	end

	// ----------------------------------------
	// Duplex and flow control selection
	// ----------------------------------------
	logic phy_full_duplex;
	logic mac_full_duplex;
	mac_pkg::flow_mode_e flow_mode;
	always_comb begin
		// PHY duplex from negotiation or management register 0 bit 8 [RULE6] [RULE11]
		phy_full_duplex = phy_an_enable ? phy_an_full_duplex : phy_mgmt_register[8];
		// MAC duplex only from configuration or tracking the PHY [RULE5] [RULE8]
		mac_full_duplex = ctrl_r[`CTRL_DUPLEX_TRACK] ? phy_full_duplex : ctrl_r[`CTRL_FULL_DUPLEX];
		// Pause-frame modes chosen by configuration [RULE9] [RULE10]
		flow_mode = mac_pkg::flow_mode_e'(ctrl_r[`CTRL_FLOW_LSB +: 2]);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phy_adv_full_duplex <= 1'b1; // [RULE7]
			phy_mgmt_wdata <= 16'h0000;
			phy_mgmt_wr <= 1'b0;
		end else begin
			phy_adv_full_duplex <= 1'b1; // [RULE7]
			phy_mgmt_wr <= reg_wr && reg_addr == `REG_STATUS; // [RULE11]
			if (reg_wr && reg_addr == `REG_STATUS)
				phy_mgmt_wdata <= reg_wdata[15:0];
		end
	end

	// ----------------------------------------
	// Crossings between core and link clocks
	// ----------------------------------------
	logic tx_tgl_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			tx_tgl_r <= 1'b0;
		else if (tx_go_r)
			tx_tgl_r <= ~tx_tgl_r;
	end
	logic [3:0] tx_cfg_s;
	level_sync #(.WIDTH(4)) u_tx_sync (
		.clk(mii_tx_clk),
		.d({tx_tgl_r, mac_full_duplex, flow_mode == mac_pkg::FLOW_RX, ctrl_r[`CTRL_SPEED_100]}),
		.q(tx_cfg_s)
	);
	logic [1:0] rx_cfg_s;
	logic [1:0] rx_pins_s;
	level_sync #(.WIDTH(2)) u_rx_cfg_sync (
		.clk(mii_rx_clk),
		.d({ctrl_r[`CTRL_IGNORE_UL], ctrl_r[`CTRL_LONG_OK]}),
		.q(rx_cfg_s[1:0])
	);
	logic [1:0] tx_pins_s;
	level_sync #(.WIDTH(2)) u_tx_pin_sync (
		.clk(mii_tx_clk),
		.d({mii_crs, mii_col}),
		.q(tx_pins_s)
	);
	// Reset reaches each link domain through its own synchroniser
	logic tx_rst_n_s;
	logic rx_rst_n_s;
	level_sync #(.WIDTH(1)) u_tx_rst_sync (
		.clk(mii_tx_clk),
		.d(rst_n),
		.q(tx_rst_n_s)
	);
	level_sync #(.WIDTH(1)) u_rx_rst_sync (
		.clk(mii_rx_clk),
		.d(rst_n),
		.q(rx_rst_n_s)
	);

	// ----------------------------------------
	// Transmit on the link clock
	// ----------------------------------------
	// Preamble 15 nibbles 5, SFD nibble D, one data byte, no CRC generation here
	typedef enum {TX_IDLE, TX_DEFER, TX_PRE, TX_DATA, TX_JAM, TX_BACKOFF} tx_state_e;
	tx_state_e tx_state_r;
	logic tx_tgl_seen_r;
	logic [7:0] tx_cnt_r;
	logic [7:0] tx_coll_r;
	logic [7:0] lfsr_r;
	always_ff @(posedge mii_tx_clk) begin
		if (!tx_rst_n_s) begin
			tx_state_r <= TX_IDLE;
			tx_tgl_seen_r <= 1'b0;
			tx_cnt_r <= 8'h00;
			tx_coll_r <= 8'h00;
			lfsr_r <= 8'h5A;
			mii_txd <= 4'h0;
			mii_tx_en <= 1'b0;
		end else begin
			lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5]};
			unique case (tx_state_r)
				TX_IDLE: begin
					mii_tx_en <= 1'b0;
					if (tx_cfg_s[3] != tx_tgl_seen_r) begin
						tx_tgl_seen_r <= tx_cfg_s[3];
						tx_coll_r <= 8'h00;
						tx_state_r <= TX_DEFER;
					end
				end
				TX_DEFER: begin
					// Full duplex starts regardless of receive activity [RULE3]
					if (tx_cfg_s[2] || !tx_pins_s[1]) begin // [RULE1]
						tx_cnt_r <= 8'h00;
						tx_state_r <= TX_PRE;
					end
				end
				TX_PRE: begin
					mii_tx_en <= 1'b1;
					mii_txd <= (tx_cnt_r == 8'h0F) ? 4'hD : 4'h5; // [RULE2]
					tx_cnt_r <= tx_cnt_r + 8'h01;
					if (tx_cnt_r == 8'h0F) begin
						tx_cnt_r <= 8'h00;
						tx_state_r <= TX_DATA;
					end
				end
				TX_DATA: begin
					mii_txd <= tx_cnt_r[0] ? tx_byte_r[7:4] : tx_byte_r[3:0];
					tx_cnt_r <= tx_cnt_r + 8'h01;
					if (tx_cnt_r == 8'h01)
						tx_state_r <= TX_IDLE;
				end
				TX_JAM: begin
					mii_txd <= 4'h5;
					tx_cnt_r <= tx_cnt_r + 8'h01;
					if (tx_cnt_r == 8'h07) begin
						mii_tx_en <= 1'b0;
						tx_cnt_r <= lfsr_r & ((8'h01 << tx_coll_r[2:0]) - 8'h01);
						tx_state_r <= (tx_coll_r >= 8'(MAX_COLL)) ? TX_IDLE : TX_BACKOFF;
					end
				end
				TX_BACKOFF: begin
					mii_tx_en <= 1'b0;
					tx_cnt_r <= tx_cnt_r - 8'h01;
					if (tx_cnt_r == 8'h00)
						tx_state_r <= TX_DEFER;
				end
			endcase
			// Half duplex collision: jam then back off, or go idle after jamming for the MAX_COLL-th collision [RULE1]
			if (!tx_cfg_s[2] && tx_pins_s[0] && (tx_state_r == TX_PRE || tx_state_r == TX_DATA)) begin
				tx_cnt_r <= 8'h00;
				tx_coll_r <= tx_coll_r + 8'h01;
				tx_state_r <= TX_JAM;
			end
		end
	end

	// ----------------------------------------
	// Receive on the link clock
	// ----------------------------------------
	logic [3:0] rxd_s;
	logic [3:0] rxd_m_r;
	logic dv_m_r;
	logic dv_s;
	always_ff @(posedge mii_rx_clk) begin
		rxd_m_r <= mii_rxd;
		dv_m_r <= mii_rx_dv;
		rxd_s <= rxd_m_r;
		dv_s <= dv_m_r;
	end
	assign rx_pins_s = {dv_s, 1'b0};

	logic rx_in_frame_r;
	logic rx_sfd_seen_r;
	logic [15:0] rx_nib_r;
	logic [47:0] rx_dest_r;
	logic rx_done_tgl_r;
	logic rx_ok_r;
	logic [15:0] rx_bytes_r;
	logic addr_ok;
	rx_addr_filter u_filter (
		.dest_addr(rx_dest_r),
		.station_address(station_address_r),
		.ignore_ul(rx_cfg_s[1]),
		.accept(addr_ok)
	);
	always_ff @(posedge mii_rx_clk) begin
		if (!rx_rst_n_s) begin
			rx_in_frame_r <= 1'b0;
			rx_sfd_seen_r <= 1'b0;
			rx_nib_r <= 16'h0000;
			rx_dest_r <= 48'h0;
			rx_done_tgl_r <= 1'b0;
			rx_ok_r <= 1'b0;
			rx_bytes_r <= 16'h0000;
		end else if (rx_pins_s[1]) begin
			// Frame begins only on PHY valid-data indication [RULE4]
			rx_in_frame_r <= 1'b1;
			if (!rx_sfd_seen_r) begin
				if (rxd_s == 4'hD)
					rx_sfd_seen_r <= 1'b1;
			end else begin
				rx_nib_r <= rx_nib_r + 16'h0001;
				if (rx_nib_r < 16'd12)
					rx_dest_r[rx_nib_r[3:0]*4 +: 4] <= rxd_s;
			end
		end else if (rx_in_frame_r) begin
			rx_in_frame_r <= 1'b0;
			rx_sfd_seen_r <= 1'b0;
			rx_nib_r <= 16'h0000;
			rx_bytes_r <= rx_nib_r >> 1;
			// Length check: long frames need the long-ok bit [RULE14] [RULE16]
			rx_ok_r <= addr_ok && ((rx_nib_r >> 1) <= `MAX_FRAME_BYTES || rx_cfg_s[0]);
			rx_done_tgl_r <= ~rx_done_tgl_r;
		end
	end

	// ----------------------------------------
	// Frame result back in the core domain
	// ----------------------------------------
	logic [2:0] done_s_r;
	logic [15:0] rx_count_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			done_s_r <= 3'b000;
			rx_count_r <= 16'h0000;
			rx_frame_accepted <= 1'b0;
			rx_frame_dropped <= 1'b0;
		end else begin
			done_s_r <= {done_s_r[1:0], rx_done_tgl_r};
			rx_frame_accepted <= (done_s_r[2] ^ done_s_r[1]) && rx_ok_r;
			rx_frame_dropped <= (done_s_r[2] ^ done_s_r[1]) && !rx_ok_r;
			if ((done_s_r[2] ^ done_s_r[1]) && rx_ok_r)
				rx_count_r <= rx_count_r + 16'h0001;
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`REG_CTRL: reg_rdata <= ctrl_r;
				`REG_ADDR_LO: reg_rdata <= station_address_r[31:0];
				`REG_ADDR_HI: reg_rdata <= {16'h0000, station_address_r[47:32]};
				`REG_STATUS: reg_rdata <= {14'h0, mac_full_duplex, phy_full_duplex, phy_mgmt_register};
				`REG_RX_COUNT: reg_rdata <= {16'h0000, rx_count_r};
				`REG_RX_DATA: reg_rdata <= {16'h0000, rx_bytes_r};
				default: reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end
endmodule
`default_nettype wire

// ==== design/mac_regs.svh ====
// Register offsets, field positions, reset value, frame length limit and address bit of the media access unit
`ifndef MAC_REGS_SVH
`define MAC_REGS_SVH
`define REG_CTRL 4'h0
`define REG_ADDR_LO 4'h1
`define REG_ADDR_HI 4'h2
`define REG_STATUS 4'h3
`define REG_RX_COUNT 4'h4
`define REG_TX_DATA 4'h5
`define REG_RX_DATA 4'h6
`define CTRL_FULL_DUPLEX 0
`define CTRL_DUPLEX_TRACK 1
`define CTRL_FLOW_LSB 2
`define CTRL_IGNORE_UL 4
`define CTRL_LONG_OK 5
`define CTRL_TX_GO 6
`define CTRL_SPEED_100 7
`define CTRL_RESET 32'h0000_0080
`define MAX_FRAME_BYTES 16'h05EE
`define UL_BIT 1
`endif

// ==== design/mac_pkg.sv ====
// Types shared by the media access unit files
package mac_pkg;
	typedef enum logic [1:0] {FLOW_NONE, FLOW_TX, FLOW_RX, FLOW_RSVD} flow_mode_e;
endpackage

// ==== design/level_sync.sv ====
// Two flip-flop synchroniser for a level crossing into a clock domain
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;
	always_ff @(posedge clk) begin
		meta_r <= d;
		q <= meta_r;
	end
endmodule
`default_nettype wire

// ==== design/rx_addr_filter.sv ====
// Destination address filter with optional don't-care on the universal/local bit
`timescale 1ns/1ps
`default_nettype none
`include "mac_regs.svh"
module rx_addr_filter (
	input wire logic [47:0] dest_addr,
	input wire logic [47:0] station_address,
	input wire logic ignore_ul,
	output logic accept
);
	logic [47:0] care;
	always_comb begin
		care = 48'hFFFF_FFFF_FFFF;
		care[`UL_BIT] = ~ignore_ul; // [RULE12]
		// Individual match uses the mask; broadcast and multicast never do [RULE13]
		accept = (((dest_addr ^ station_address) & care) == 48'h0) || dest_addr[0];
	end
endmodule
`default_nettype wire

// ==== verif/mac_sva.sv ====
// Port checker for the media access unit
`timescale 1ns/1ps
`default_nettype none
`include "mac_regs.svh"
module mac_sva (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic phy_adv_full_duplex,
	input wire logic phy_an_enable,
	input wire logic phy_an_full_duplex,
	input wire logic [15:0] phy_mgmt_register,
	input wire logic [15:0] phy_mgmt_wdata,
	input wire logic phy_mgmt_wr,
	input wire logic rx_frame_accepted,
	input wire logic rx_frame_dropped
);
	// ----------
	// Assertions
	// ----------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_rd_stat;
		reg_rd && reg_addr == `REG_STATUS;
	endsequence
	sequence s_wr_ctrl;
		reg_wr && reg_addr == `REG_CTRL;
	endsequence
	a_adv_full: assert property (phy_adv_full_duplex) else $error("advertise low");
	a_stat_mgmt: assert property (s_rd_stat |=>
		reg_rdata[15:0] == $past(phy_mgmt_register)) else $error("mgmt read");
	a_phy_dup: assert property (s_rd_stat |=> reg_rdata[16] ==
		($past(phy_an_enable) ? $past(phy_an_full_duplex) : $past(phy_mgmt_register[8]))) else $error("phy duplex");
	a_flow_back: assert property (s_wr_ctrl ##1 (reg_rd && reg_addr == `REG_CTRL) |=>
		reg_rdata[3:2] == $past(reg_wdata[3:2], 2)) else $error("flow mode");
	a_mgmt_wr: assert property (reg_wr && reg_addr == `REG_STATUS |=>
		phy_mgmt_wr && phy_mgmt_wdata == $past(reg_wdata[15:0])) else $error("mgmt write");
	a_mgmt_cause: assert property ($rose(phy_mgmt_wr) |->
		$past(reg_wr) && $past(reg_addr) == `REG_STATUS) else $error("mgmt stray");
	a_rx_excl: assert property (!(rx_frame_accepted && rx_frame_dropped)) else $error("both results");
	a_rx_pulse: assert property ((rx_frame_accepted || rx_frame_dropped) |=>
		!(rx_frame_accepted || rx_frame_dropped)) else $error("long result");
endmodule
bind csma_cd_mac_duplex_filter mac_sva u_mac_sva (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .phy_adv_full_duplex, .phy_an_enable, .phy_an_full_duplex, .phy_mgmt_register,
	.phy_mgmt_wdata, .phy_mgmt_wr, .rx_frame_accepted, .rx_frame_dropped);
`default_nettype wire

// ==== verif/phy_model.sv ====
// Behavioural PHY on the far side of the MII
`timescale 1ns/1ps
`default_nettype none
module phy_model (
	output logic mii_tx_clk,
	output logic mii_rx_clk,
	input wire logic [3:0] mii_txd,
	input wire logic mii_tx_en,
	output logic mii_crs,
	output logic mii_col,
	output logic [3:0] mii_rxd,
	output logic mii_rx_dv
);
	// -----------------
	// Clocks and frames
	// -----------------
	logic [3:0] tx_q[$];
	logic busy;
	logic col_arm = 1'b0;
	initial begin
		mii_tx_clk = 1'b0;
		#23;
		forever #62.5 mii_tx_clk = ~mii_tx_clk;
	end
	initial begin
		busy = 1'b0;
		mii_crs = 1'b0;
		mii_rx_dv = 1'b0;
		mii_rxd = 4'h0;
		mii_rx_clk = 1'b0;
		forever #62.5 mii_rx_clk = ~mii_rx_clk;
	end
	// Idle data toggles so stale nibbles never look valid
	always @(posedge mii_rx_clk) if (!busy) mii_rxd <= ~mii_rxd;
	always @(posedge mii_tx_clk) if (mii_tx_en) tx_q.push_back(mii_txd);
	// Collision raised while armed and the unit is sending
	always @(posedge mii_tx_clk) mii_col <= col_arm && mii_tx_en;
	task automatic send(input logic [47:0] dest, input int nbytes);
		logic [7:0] b;
		busy = 1'b1;
		@(posedge mii_rx_clk);
		mii_crs <= 1'b1;
		mii_rx_dv <= 1'b1;
		for (int i = 0; i < 16 + 2 * nbytes; i++) begin
			b = (i < 28) ? dest[8 * ((i - 16) / 2) +: 8] : 8'(i);
			mii_rxd <= (i < 15) ? 4'h5 : (i == 15) ? 4'hD : (i[0] ? b[7:4] : b[3:0]);
			@(posedge mii_rx_clk);
		end
		mii_rx_dv <= 1'b0;
		mii_crs <= 1'b0;
		busy = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== verif/tb_csma_cd_mac_duplex_filter.sv ====
// Self-checking bench for the media access unit
`timescale 1ns/1ps
`default_nettype none
`include "mac_regs.svh"
module tb_csma_cd_mac_duplex_filter;
	// --------------------
	// Signals and instances
	// --------------------
	localparam logic [47:0] LOADED = 48'h0A_0B_0C_0D_0E_10;
	localparam logic [47:0] NEW_ADDR = 48'h1F_2E_3D_4C_5B_64;
	logic core_clk, rst_n, reg_wr, reg_rd, cmd, adv, an_en, an_fd, mgmt_wr;
	logic tx_clk, rx_clk, tx_en, crs, col, rx_dv, acc, drop;
	logic [3:0] reg_addr, txd, rxd;
	logic [31:0] reg_wdata, reg_rdata;
	logic [47:0] setup_address;
	logic [15:0] mgmt_reg, mgmt_wdata;
	int errors, total_checks;
	csma_cd_mac_duplex_filter #(.LOADED_ADDRESS(LOADED)) u_csma_cd_mac_duplex_filter (.core_clk, .rst_n,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .station_address_setup_cmd(cmd), .setup_address,
		.phy_adv_full_duplex(adv), .phy_an_enable(an_en), .phy_an_full_duplex(an_fd), .phy_mgmt_register(mgmt_reg),
		.phy_mgmt_wdata(mgmt_wdata), .phy_mgmt_wr(mgmt_wr), .mii_tx_clk(tx_clk), .mii_txd(txd), .mii_tx_en(tx_en),
		.mii_crs(crs), .mii_col(col), .mii_rx_clk(rx_clk), .mii_rxd(rxd), .mii_rx_dv(rx_dv),
		.rx_frame_accepted(acc), .rx_frame_dropped(drop));
	phy_model u_phy_model (.mii_tx_clk(tx_clk), .mii_rx_clk(rx_clk), .mii_txd(txd), .mii_tx_en(tx_en),
		.mii_crs(crs), .mii_col(col), .mii_rxd(rxd), .mii_rx_dv(rx_dv));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic timeout;
		errors++;
		$display("ERROR %0t wait timed out", $time);
		end_of_test();
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input bit keep = 0);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		if (!keep) begin
			reg_wr <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge core_clk);
	endtask
	task automatic frame(input logic [47:0] dest, input int n, input logic exp);
		u_phy_model.send(dest, n);
		repeat (400) begin
			@(posedge core_clk);
			#1;
			if (acc || drop)
				break;
		end
		if (!(acc || drop))
			timeout();
		check(32'(acc), 32'(exp));
		@(posedge core_clk);
	endtask
	task automatic t_regs;
		logic [31:0] v;
		rd(`REG_CTRL, v);
		check(v, `CTRL_RESET);
		check(32'(adv), 32'h1);
		wr(4'hF, 32'h3);
		rd(4'hF, v);
		check(v, 32'h0);
		rd(`REG_CTRL, v);
		check(v, `CTRL_RESET);
		for (int m = 0; m < 3; m++) begin
			wr(`REG_CTRL, `CTRL_RESET | 32'(m << 2), 1);
			rd(`REG_CTRL, v);
			check(32'(v[3:2]), 32'(m));
		end
		$display("regs done");
	endtask
	task automatic t_duplex;
		logic [31:0] v;
		an_en <= 1'b0;
		an_fd <= 1'b0;
		mgmt_reg <= 16'h0100;
		repeat (3) @(posedge core_clk);
		rd(`REG_STATUS, v);
		check(32'(v[16:0]), 32'h10100);
		an_en <= 1'b1;
		wr(`REG_CTRL, 32'h82);
		rd(`REG_STATUS, v);
		check(32'(v[17:16]), 32'h0);
		an_fd <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(`REG_STATUS, v);
		check(32'(v[17:16]), 32'h3);
		wr(`REG_CTRL, 32'h80);
		rd(`REG_STATUS, v);
		check(32'(v[17:16]), 32'h1);
		wr(`REG_STATUS, 32'hBEEF);
		check(32'(mgmt_wdata), 32'hBEEF);
		$display("duplex done");
	endtask
	task automatic t_filter;
		logic [31:0] v;
		frame(LOADED, 20, 1);
		frame(LOADED ^ 48'h2, 20, 0);
		wr(`REG_CTRL, 32'h90);
		frame(LOADED ^ 48'h2, 20, 1);
		frame(LOADED ^ 48'h4, 20, 0);
		frame(48'hFFFF_FFFF_FFFF, 20, 1);
		cmd <= 1'b1;
		setup_address <= NEW_ADDR;
		@(posedge core_clk);
		cmd <= 1'b0;
		@(posedge core_clk);
		frame(LOADED, 20, 0);
		frame(NEW_ADDR ^ 48'h2, 20, 1);
		rd(`REG_RX_COUNT, v);
		check(v, 32'h4);
		$display("filter done");
	endtask
	task automatic t_tx;
		int n;
		wr(`REG_TX_DATA, 32'hA7);
		u_phy_model.tx_q.delete();
		fork
			frame(NEW_ADDR, 20, 1);
			begin
				repeat (40) @(posedge core_clk);
				wr(`REG_CTRL, 32'hC1);
			end
		join
		for (n = 0; n < 2000 && (u_phy_model.tx_q.size() < 18 || tx_en); n++)
			@(posedge core_clk);
		if (n == 2000)
			timeout();
		check(32'(u_phy_model.tx_q.size()), 32'h12);
		foreach (u_phy_model.tx_q[i])
			check(32'(u_phy_model.tx_q[i]), i < 15 ? 32'h5 : i == 15 ? 32'hD : i == 16 ? 32'h7 : 32'hA);
		$display("tx done");
	endtask
	task automatic t_coll;
		int n, base;
		u_phy_model.tx_q.delete();
		u_phy_model.col_arm <= 1'b1;
		wr(`REG_CTRL, 32'hC0);
		for (n = 0; n < 1000 && !col; n++)
			@(posedge core_clk);
		if (n == 1000)
			timeout();
		u_phy_model.col_arm <= 1'b0;
		for (n = 0; n < 2000 && (u_phy_model.tx_q.size() < 19 || tx_en); n++)
			@(posedge core_clk);
		if (n == 2000)
			timeout();
		check(32'(u_phy_model.tx_q.size() > 18), 32'h1);
		base = u_phy_model.tx_q.size() - 18;
		for (int i = 0; i < 18; i++)
			check(32'(u_phy_model.tx_q[base + i]), i < 15 ? 32'h5 : i == 15 ? 32'hD : i == 16 ? 32'h7 : 32'hA);
		$display("collision done");
	endtask
	task automatic t_long;
		wr(`REG_CTRL, 32'h80);
		frame(NEW_ADDR, 1518, 1);
		frame(NEW_ADDR, 1519, 0);
		$display("long done");
	endtask
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		errors = 0;
		total_checks = 0;
		rst_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		cmd = 1'b0;
		setup_address = 48'h0;
		an_en = 1'b1;
		an_fd = 1'b1;
		mgmt_reg = 16'h0;
		// Long enough for four edges of each link clock
		repeat (64) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_duplex();
		t_filter();
		t_tx();
		t_coll();
		t_long();
		end_of_test();
	end
endmodule
`default_nettype wire
